// File: shared/ptm_map.vh
// Constants for the bus target and initiator port.
// Assumes one bus clock, clk_sys, shared with the whole bus.
`ifndef PTM_MAP_VH
`define PTM_MAP_VH

`define PTM_CMD_INTA    4'h0
`define PTM_CMD_SPEC    4'h1
`define PTM_CMD_IO_RD   4'h2
`define PTM_CMD_IO_WR   4'h3
`define PTM_CMD_MEM_RD  4'h6
`define PTM_CMD_MEM_WR  4'h7
`define PTM_CMD_CFG_RD  4'ha
`define PTM_CMD_CFG_WR  4'hb
`define PTM_CMD_MRM     4'hc
`define PTM_CMD_DAC     4'hd
`define PTM_CMD_MRL     4'he
`define PTM_CMD_MWI     4'hf

`define PTM_BE_FULL     4'h0
`define PTM_BE_NONE     4'hf
`define PTM_CFG_BYTES   256
`define PTM_RD_ZERO     32'h00000000
`define PTM_FIFO_DEPTH  8
`define PTM_FIFO_AW     3

`endif

// File: verif/ptm_mem_model.sv
// Arbiter and memory target facing the port as initiator.
// Assumes resolved pins; trdy idles high as if pulled up.
module ptm_mem_model (
  // Clock, reset, test controls
  input  logic        clk_sys,
  input  logic        srst,
  input  logic        block,
  input  logic        slow,
  // Bus pins
  input  logic        req_n,
  input  logic        frame_n,
  input  logic        irdy_n,
  input  logic [31:0] ad,
  input  logic [3:0]  cbe_n,
  output logic        gnt_n,
  output logic        trdy_n,
  output logic        ad_en,
  output logic [31:0] ad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic frame_q;
  logic gnt_q;

  always @(posedge clk_sys) begin
    frame_q <= frame_n;
    gnt_q <= gnt_n;
    if (srst) begin
      gnt_n <= 1'b1;
      trdy_n <= 1'b1;
      ad_en <= 1'b0;
    end else begin
      // Slow mode gives one-cycle grants, lost as frame starts
      gnt_n <= req_n | block | (slow & !gnt_n);
      if (!frame_n && frame_q && !gnt_q && cbe_n == 4'h6) begin
        ad_o <= ad;
        ad_en <= 1'b1;
        trdy_n <= slow;
      end else if (ad_en) begin
        if (!irdy_n && !trdy_n) begin
          ad_o <= ad_o + 32'h4;
          trdy_n <= frame_n | slow;
          ad_en <= !frame_n;
        end else begin
          trdy_n <= 1'b0;
        end
      end
    end
  end
endmodule // ptm_mem_model

// File: verif/ptm_port_asserts.sv
// Pin-level checks of the host port, both target and initiator.
// Assumes it is bound into ptm_port; one clock, sync reset.
module ptm_port_asserts (
  // Watched ports
  input logic        clk_sys,
  input logic        srst,
  input logic        frame_n_in,
  input logic        irdy_n_in,
  input logic        trdy_n_in,
  input logic [3:0]  cbe_n_in,
  input logic        frame_n_out,
  input logic        frame_oe_n,
  input logic        irdy_n_out,
  input logic        irdy_oe_n,
  input logic        trdy_n_out,
  input logic        trdy_oe_n,
  input logic        devsel_n_out,
  input logic        devsel_oe_n,
  input logic [3:0]  cbe_n_out,
  input logic        cbe_oe_n,
  input logic [31:0] ad_out,
  input logic        ad_oe_n,
  input logic        req_n,
  input logic        gnt_n,
  input logic        reg_rd,
  input logic        reg_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_frame_on_gnt: assert property ($fell(frame_n_out) |-> $past(gnt_n) == 1'b0)
    else $error("frame started without grant");
  a_req_drop: assert property ($fell(frame_n_out) |-> req_n && $past(req_n) == 1'b0)
    else $error("request not dropped with frame");
  a_read_cmd_irdy: assert property ($fell(frame_n_out) |-> cbe_n_out == 4'h6 ##1 !irdy_n_out && !irdy_oe_n)
    else $error("initiator read start wrong");
  a_irdy_hold: assert property (!irdy_oe_n && !irdy_n_out && (trdy_n_in || !frame_n_out) |=> !irdy_n_out)
    else $error("irdy dropped early");
  a_data_be: assert property (!irdy_oe_n && !irdy_n_out |-> !cbe_oe_n && cbe_n_out == 4'h0)
    else $error("byte enables not full");
  a_end_order: assert property ($rose(frame_n_out) && !frame_oe_n |-> !irdy_n_out)
    else $error("frame ended after irdy");
  a_no_claim: assert property ($fell(frame_n_in) && frame_oe_n && cbe_n_in inside {4'h0, 4'h1, 4'hd}
    |=> devsel_oe_n [*4])
    else $error("unsupported command claimed");
  a_read_seq: assert property (reg_rd |-> !devsel_n_out && !devsel_oe_n ##1 !ad_oe_n && !trdy_n_out)
    else $error("target read order wrong");
  a_read_zero: assert property (!ad_oe_n && !trdy_oe_n && !trdy_n_out && cbe_n_in == 4'hf |-> ad_out == 32'h0)
    else $error("disabled read not zero");
  a_write_skip: assert property (reg_wr |-> $past(cbe_n_in) != 4'hf && $past(irdy_n_in) == 1'b0)
    else $error("register write wrong");
  a_tgt_release: assert property (!trdy_oe_n && !trdy_n_out && !irdy_n_in
    |=> trdy_n_out && devsel_n_out ##1 trdy_oe_n && devsel_oe_n)
    else $error("target not released");

  c_master: cover property ($fell(frame_n_out));
  c_read: cover property (reg_rd);
  c_write: cover property (reg_wr);
endmodule // ptm_port_asserts

bind ptm_port ptm_port_asserts CHK (.clk_sys, .srst, .frame_n_in, .irdy_n_in, .trdy_n_in, .cbe_n_in,
  .frame_n_out, .frame_oe_n, .irdy_n_out, .irdy_oe_n, .trdy_n_out, .trdy_oe_n, .devsel_n_out,
  .devsel_oe_n, .cbe_n_out, .cbe_oe_n, .ad_out, .ad_oe_n, .req_n, .gnt_n, .reg_rd, .reg_wr);

// File: verif/ptm_port_test.sv
// Self-checking bench of the host port: target cycles and burst reads.
// Assumes pull-ups on control lines; host cycles driven here.
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s exp %0h got %0h", n, e, g); end end

module ptm_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, srst = 1, h_frame = 1, h_irdy = 1, h_en = 0, idsel = 0;
  logic block = 0, slow = 0, mst_start = 0, rd_ready = 0, m_en, trdy_m, gnt_n;
  logic [3:0] h_cbe = 0, mst_len = 0;
  logic [31:0] h_ad = 0, pat = 0, mst_addr = 0, wr_d, m_ad;
  int miscompares = 0, n_tests = 0, wr_n = 0, c;
  wire [31:0] ad_out, reg_addr, reg_wdata, rd_data;
  wire [3:0] cbe_n_out;
  wire ad_oe_n, cbe_oe_n, frame_n_out, frame_oe_n, irdy_n_out, irdy_oe_n, trdy_n_out, trdy_oe_n;
  wire req_n, reg_wr, mst_ready, mst_done, rd_valid, par, par_oe_n, cfg;
  // Undriven AD shows a moving pattern, never a stale value
  wire [31:0] ad_w = !ad_oe_n ? ad_out : m_en ? m_ad : h_en ? h_ad : pat;
  wire [3:0] cbe_w = cbe_oe_n ? h_cbe : cbe_n_out;
  wire frame_w = frame_oe_n ? h_frame : frame_n_out;
  wire irdy_w = irdy_oe_n ? h_irdy : irdy_n_out;
  wire trdy_w = trdy_oe_n ? trdy_m : trdy_n_out;

  ptm_port DUT (.clk_sys, .srst, .ad_in(ad_w), .ad_out, .ad_oe_n, .cbe_n_in(cbe_w), .cbe_n_out, .cbe_oe_n,
    .par_out(par), .par_oe_n, .frame_n_in(frame_w), .frame_n_out, .frame_oe_n, .irdy_n_in(irdy_w),
    .irdy_n_out, .irdy_oe_n, .trdy_n_in(trdy_w), .trdy_n_out, .trdy_oe_n, .devsel_n_out(), .devsel_oe_n(),
    .idsel, .req_n, .gnt_n, .reg_rd(), .reg_wr, .reg_cfg(cfg), .reg_addr, .reg_wdata, .reg_rdata(~reg_addr),
    .mst_start, .mst_ready, .mst_addr, .mst_len, .mst_done, .rd_valid, .rd_ready, .rd_data);
  ptm_mem_model MEM (.clk_sys, .srst, .block, .slow, .req_n, .frame_n(frame_w), .irdy_n(irdy_w),
    .ad(ad_w), .cbe_n(cbe_w), .gnt_n, .trdy_n(trdy_m), .ad_en(m_en), .ad_o(m_ad));

  initial forever #25 clk_sys = ~clk_sys;
  always @(negedge clk_sys) pat <= pat + 32'h01010101;
  always @(negedge clk_sys) if (reg_wr === 1'b1) begin
    wr_n++;
    wr_d = reg_wdata;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic bail;
    miscompares++;
    summarize();
  endtask

  // One host target cycle; reads and writes differ by the low command bit
  task automatic t_cyc(input logic [3:0] cmd, input logic [31:0] a, input logic sel,
                       input logic [3:0] be, input logic [31:0] d, input logic claim);
    int i, w0;
    w0 = wr_n;
    @(negedge clk_sys);
    h_frame = 0; h_en = 1; h_ad = a; h_cbe = cmd; idsel = sel;
    @(negedge clk_sys);
    h_frame = 1; h_irdy = 0; h_cbe = be; h_en = cmd[0]; h_ad = d; idsel = 0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      if (trdy_w === 1'b0) break;
    end
    `CHK("claim", claim, i < 8)
    if (claim) `CHK("cfg", cmd[3:1] == 3'h5, cfg)
    if (claim && !cmd[0]) `CHK("rdata", be == 4'hf ? 32'h0 : ~a, ad_w)
    @(negedge clk_sys);
    h_irdy = 1; h_en = 0;
    // Parity of the read word and enables trails the data by one cycle
    if (claim && !cmd[0]) `CHK("parity", {1'b0, (^(be == 4'hf ? 32'h0 : ~a) ^ (^be))}, {par_oe_n, par})
    repeat (4) @(negedge clk_sys);
    if (cmd[0]) `CHK("writes", w0 + (claim && be != 4'hf), wr_n)
    if (cmd[0] && claim && be != 4'hf) `CHK("wdata", d, wr_d)
  endtask

  // Burst read; the stream is left stalled until the transfer is done
  task automatic t_mst(input logic [31:0] a, input logic [3:0] len, input logic s, input logic blk);
    int i, n;
    n = len == 0 ? 1 : len > 8 ? 8 : len;
    slow = s; block = blk;
    for (i = 0; i < 50 && mst_ready !== 1'b1; i++) @(negedge clk_sys);
    if (mst_ready !== 1'b1) bail();
    mst_addr = a; mst_len = len; mst_start = 1;
    @(negedge clk_sys);
    mst_start = 0;
    if (blk) begin
      repeat (10) @(negedge clk_sys);
      `CHK("req", 1'b0, req_n)
      `CHK("idle", 1'b1, frame_w)
      // Busy bus lets the short grants come and go unused
      h_irdy = 0; block = 0;
      repeat (4) @(negedge clk_sys);
      `CHK("wait", 1'b1, frame_w)
      h_irdy = 1;
    end
    for (i = 0; i < 80 && mst_done !== 1'b1; i++) @(negedge clk_sys);
    if (mst_done !== 1'b1) bail();
    repeat (2) @(negedge clk_sys);
    `CHK("busy", 1'b0, mst_ready)
    for (i = 0; i < n; i++) begin
      `CHK("rvalid", 1'b1, rd_valid)
      `CHK("rdata", a + 4 * i, rd_data)
      rd_ready = 1;
      @(negedge clk_sys);
      rd_ready = 0;
      @(negedge clk_sys);
    end
    `CHK("empty", 1'b0, rd_valid)
  endtask

  initial begin
    repeat (16) @(negedge clk_sys);
    srst = 0;
    repeat (2) @(negedge clk_sys);
    for (c = 0; c < 16; c++)
      t_cyc(c[3:0], c[3:1] == 3'h1 || c[3:1] == 3'h5 ? 32'h10 : 32'h10010, c[3:1] == 3'h5, 4'h0,
            32'h12345670 + c, 16'hdccc >> c);
    t_cyc(4'h6, 32'h10020, 0, 4'hf, 32'h0, 1);
    t_cyc(4'h7, 32'h10020, 0, 4'hf, 32'h55, 1);
    t_cyc(4'ha, 32'h10, 0, 4'h0, 32'h0, 0);
    t_cyc(4'h2, 32'h1000, 0, 4'h0, 32'h0, 0);
    t_cyc(4'hb, 32'hfc, 1, 4'h0, 32'hcafe0001, 1);
    t_mst(32'h2000, 4'h2, 0, 0);
    t_mst(32'h3000, 4'h8, 1, 1);
    t_mst(32'h4000, 4'h0, 0, 0);
    t_mst(32'h5000, 4'hc, 0, 0);
    t_cyc(4'h6, 32'h10040, 0, 4'h0, 32'h0, 1);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bail();
  end
endmodule // ptm_port_test

// File: verilog/ptm_fifo.v
// Word FIFO with a registered output stage.
// Assumes one clock and a synchronous active-high reset.
module ptm_fifo #(
  parameter W  = 32,
  parameter D  = 8,
  parameter AW = 3
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          srst,
  // Fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // Drain side
  output reg           out_valid,
  input  wire          out_ready,
  output reg  [W-1:0]  out_data,
  // Words held, output stage included
  output wire [AW+1:0] level
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0]   cnt;
  wire push = in_valid && in_ready;
  wire pop  = (cnt != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  assign in_ready = (cnt != D[AW:0]);
  assign level    = {1'b0, cnt} + {{(AW+1){1'b0}}, out_valid};

  always @(posedge clk_sys) begin
    if (push)
      mem[wp] <= in_data;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      wp        <= {AW{1'b0}};
      rp        <= {AW{1'b0}};
      cnt       <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end else begin
      if (push)
        wp <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      if (pop) begin
        rp       <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
        out_data <= mem[rp];
      end
      if (pop)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // ptm_fifo

// File: verilog/ptm_port.v
// Bus target and burst-read initiator of the host bus port.
// Assumes clk_sys is the bus clock; pins are resolved outside.
`include "ptm_map.vh"

module ptm_port #(
  parameter [31:0] IO_BASE  = 32'h00000000,
  parameter [31:0] MEM_BASE = 32'h00010000,
  parameter [31:0] WIN_MASK = 32'h000000ff,
  parameter        DEPTH    = `PTM_FIFO_DEPTH,
  parameter        AW       = `PTM_FIFO_AW
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          srst,
  // Address and data pins
  input  wire [31:0]   ad_in,
  output reg  [31:0]   ad_out,
  output reg           ad_oe_n,
  input  wire [3:0]    cbe_n_in,
  output reg  [3:0]    cbe_n_out,
  output reg           cbe_oe_n,
  output reg           par_out,
  output reg           par_oe_n,
  // Control pins
  input  wire          frame_n_in,
  output reg           frame_n_out,
  output reg           frame_oe_n,
  input  wire          irdy_n_in,
  output reg           irdy_n_out,
  output reg           irdy_oe_n,
  input  wire          trdy_n_in,
  output reg           trdy_n_out,
  output reg           trdy_oe_n,
  output reg           devsel_n_out,
  output reg           devsel_oe_n,
  input  wire          idsel,
  // Arbitration pins
  output reg           req_n,
  input  wire          gnt_n,
  // Register side of target accesses
  output reg           reg_rd,
  output reg           reg_wr,
  output reg           reg_cfg,
  output reg  [31:0]   reg_addr,
  output reg  [31:0]   reg_wdata,
  input  wire [31:0]   reg_rdata,
  // Burst read requests
  input  wire          mst_start,
  output reg           mst_ready,
  input  wire [31:0]   mst_addr,
  input  wire [AW:0]   mst_len,
  output reg           mst_done,
  // Read data stream
  output wire          rd_valid,
  input  wire          rd_ready,
  output wire [31:0]   rd_data
);
  localparam [2:0] T_IDLE  = 3'h0;
  localparam [2:0] T_CLAIM = 3'h1;
  localparam [2:0] T_RDATA = 3'h2;
  localparam [2:0] T_WAIT  = 3'h3;
  localparam [2:0] T_WACK  = 3'h4;
  localparam [2:0] T_TURN  = 3'h5;
  localparam [2:0] T_SKIP  = 3'h6;

  localparam [2:0] M_IDLE  = 3'h0;
  localparam [2:0] M_REQ   = 3'h1;
  localparam [2:0] M_ADDR  = 3'h2;
  localparam [2:0] M_DATA  = 3'h3;
  localparam [2:0] M_END   = 3'h4;

  reg  [2:0]  t_state;
  reg  [2:0]  m_state;
  reg         frame_seen;
  reg  [3:0]  t_cmd;
  reg  [3:0]  t_be;
  reg  [AW:0] remain;
  reg  [31:0] m_addr;

  wire          fifo_in_ready;
  wire [AW+1:0] fifo_level;
  wire          m_xfer;
  wire          t_start;
  wire          bus_idle;
  wire          m_owns;

  // Claim decode; only listed commands are answered
  function claim;
    input [3:0]  cmd;
    input [31:0] addr;
    input        sel;
    reg          io_hit;
    reg          mem_hit;
    begin
      io_hit  = ((addr & ~WIN_MASK) == IO_BASE);
      mem_hit = ((addr & ~WIN_MASK) == MEM_BASE);
      case (cmd)
        `PTM_CMD_IO_RD,
        `PTM_CMD_IO_WR:  claim = io_hit;
        `PTM_CMD_MEM_RD,
        `PTM_CMD_MEM_WR,
        `PTM_CMD_MRM,
        `PTM_CMD_MRL,
        `PTM_CMD_MWI:    claim = mem_hit;
        `PTM_CMD_CFG_RD,
        `PTM_CMD_CFG_WR: claim = sel && (addr[1:0] == 2'b00);
        default:         claim = 1'b0;
      endcase
    end
  endfunction

  // Zero length would wrap the count into a 16-word burst
  function [AW:0] clip_len;
    input [AW:0] len;
    begin
      if (len == {(AW+1){1'b0}})
        clip_len = {{AW{1'b0}}, 1'b1};
      else if (len > DEPTH[AW:0])
        clip_len = DEPTH[AW:0];
      else
        clip_len = len;
    end
  endfunction

  // Own frames are not decoded as target accesses
  assign m_owns   = (m_state != M_IDLE) && (m_state != M_REQ);
  assign t_start  = !frame_n_in && frame_seen && !m_owns;
  assign bus_idle = frame_n_in && irdy_n_in && (t_state == T_IDLE);
  assign m_xfer   = (m_state == M_DATA) && !irdy_n_out && !trdy_n_in;

  ptm_fifo #(
    .W  (32),
    .D  (DEPTH),
    .AW (AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (m_xfer),
    .in_ready  (fifo_in_ready),
    .in_data   (ad_in),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data),
    .level     (fifo_level)
  );

  // Frame edge detect for target starts
  always @(posedge clk_sys) begin
    if (srst)
      frame_seen <= 1'b1;
    else
      frame_seen <= frame_n_in;
  end

  // Parity follows the driven address or data by one cycle
  always @(posedge clk_sys) begin
    if (srst) begin
      par_out  <= 1'b0;
      par_oe_n <= 1'b1;
    end else begin
      par_out  <= ^ad_out ^ ^cbe_n_in;
      par_oe_n <= ad_oe_n;
    end
  end

  // Target side
  always @(posedge clk_sys) begin
    if (srst) begin
      t_state      <= T_IDLE;
      t_cmd        <= 4'h0;
      t_be         <= `PTM_BE_FULL;
      trdy_n_out   <= 1'b1;
      trdy_oe_n    <= 1'b1;
      devsel_n_out <= 1'b1;
      devsel_oe_n  <= 1'b1;
      reg_rd       <= 1'b0;
      reg_wr       <= 1'b0;
      reg_cfg      <= 1'b0;
      reg_addr     <= 32'h0;
      reg_wdata    <= 32'h0;
    end else begin
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      case (t_state)
        T_IDLE: begin
          if (t_start) begin
            t_cmd    <= cbe_n_in;
            reg_addr <= ad_in;
            reg_cfg  <= (cbe_n_in == `PTM_CMD_CFG_RD) ||
                        (cbe_n_in == `PTM_CMD_CFG_WR);
            if (!claim(cbe_n_in, ad_in, idsel))
              t_state <= T_SKIP;
            else if (!cbe_n_in[0]) begin
              devsel_n_out <= 1'b0;
              devsel_oe_n  <= 1'b0;
              trdy_n_out   <= 1'b1;
              trdy_oe_n    <= 1'b0;
              reg_rd       <= 1'b1;
              t_state      <= T_CLAIM;
            end else
              t_state <= T_WAIT;
          end
        end
        T_CLAIM: begin
          t_be       <= cbe_n_in;
          trdy_n_out <= 1'b0;
          t_state    <= T_RDATA;
        end
        T_RDATA: begin
          if (!irdy_n_in) begin
            trdy_n_out   <= 1'b1;
            devsel_n_out <= 1'b1;
            t_state      <= T_TURN;
          end
        end
        T_WAIT: begin
          if (!irdy_n_in) begin
            reg_wdata    <= ad_in;
            t_be         <= cbe_n_in;
            devsel_n_out <= 1'b0;
            devsel_oe_n  <= 1'b0;
            trdy_n_out   <= 1'b0;
            trdy_oe_n    <= 1'b0;
            t_state      <= T_WACK;
          end
        end
        T_WACK: begin
          if (!irdy_n_in) begin
            reg_wr       <= (t_be != `PTM_BE_NONE);
            trdy_n_out   <= 1'b1;
            devsel_n_out <= 1'b1;
            t_state      <= T_TURN;
          end
        end
        T_TURN: begin
          trdy_oe_n   <= 1'b1;
          devsel_oe_n <= 1'b1;
          t_state     <= T_IDLE;
        end
        T_SKIP: begin
          // Foreign transaction: wait for the bus to go idle
          if (frame_n_in && irdy_n_in)
            t_state <= T_IDLE;
        end
        default: t_state <= T_IDLE;
      endcase
    end
  end

  // Read data onto the pins; single enables are not honoured, but all enables off reads zero
  always @(posedge clk_sys) begin
    if (srst) begin
      ad_out  <= 32'h0;
      ad_oe_n <= 1'b1;
    end else if (t_state == T_CLAIM) begin
      ad_out  <= (cbe_n_in == `PTM_BE_NONE) ? `PTM_RD_ZERO : reg_rdata;
      ad_oe_n <= 1'b0;
    end else if (t_state == T_RDATA && !irdy_n_in) begin
      ad_oe_n <= 1'b1;
    end else if (m_state == M_REQ && !gnt_n && bus_idle) begin
      ad_out  <= m_addr;
      ad_oe_n <= 1'b0;
    end else if (m_state == M_ADDR) begin
      ad_oe_n <= 1'b1;  // Memory controller drives data next
    end
  end

  // Initiator side
  always @(posedge clk_sys) begin
    if (srst) begin
      m_state     <= M_IDLE;
      m_addr      <= 32'h0;
      remain      <= {(AW+1){1'b0}};
      req_n       <= 1'b1;
      frame_n_out <= 1'b1;
      frame_oe_n  <= 1'b1;
      irdy_n_out  <= 1'b1;
      irdy_oe_n   <= 1'b1;
      cbe_n_out   <= `PTM_BE_FULL;
      cbe_oe_n    <= 1'b1;
      mst_ready   <= 1'b0;
      mst_done    <= 1'b0;
    end else begin
      mst_done <= 1'b0;
      // Only start when the whole burst fits the buffer
      mst_ready <= (m_state == M_IDLE) && !(mst_start && mst_ready) &&
                   fifo_in_ready && (fifo_level == {(AW+2){1'b0}});
      case (m_state)
        M_IDLE: begin
          if (mst_start && mst_ready) begin
            m_addr  <= mst_addr;
            remain  <= clip_len(mst_len);
            req_n   <= 1'b0;
            m_state <= M_REQ;
          end
        end
        M_REQ: begin
          // Grant must be seen on the very edge frame starts
          if (!gnt_n && bus_idle) begin
            frame_n_out <= 1'b0;
            frame_oe_n  <= 1'b0;
            irdy_n_out  <= 1'b1;
            irdy_oe_n   <= 1'b0;
            cbe_n_out   <= `PTM_CMD_MEM_RD;
            cbe_oe_n    <= 1'b0;
            req_n       <= 1'b1;
            m_state     <= M_ADDR;
          end
        end
        M_ADDR: begin
          // Grant is no longer looked at from here on
          irdy_n_out <= 1'b0;
          cbe_n_out  <= `PTM_BE_FULL;
          if (remain == {{AW{1'b0}}, 1'b1})
            frame_n_out <= 1'b1;
          m_state <= M_DATA;
        end
        M_DATA: begin
          if (m_xfer) begin
            remain <= remain - 1'b1;
            if (remain == {{(AW-1){1'b0}}, 2'b10})
              frame_n_out <= 1'b1;
            if (remain == {{AW{1'b0}}, 1'b1}) begin
              irdy_n_out <= 1'b1;
              m_state    <= M_END;
            end
          end
        end
        M_END: begin
          frame_oe_n <= 1'b1;
          irdy_oe_n  <= 1'b1;
          cbe_oe_n   <= 1'b1;
          mst_done   <= 1'b1;
          m_state    <= M_IDLE;
        end
        default: m_state <= M_IDLE;
      endcase
    end
  end
endmodule // ptm_port
